//--- verilog/output_sync_parameters.v
// Overview of operation
// - entry count register reads thirty-two, the highest sub-entry held.
// - mode 0 free run, 1 sm event, 2 sync0, 3 sync1; reset free run.
// - free run: cycle time in ns sets local timer period; resets 250000.
// - sm event mode: cycle time holds the master cycle period.
// - distributed-clock modes: cycle time equals the sync0/sync1 period.
// - read-only shift time: sync0 to outputs driven, ns, dc only, resets zero.
// - capability bit0 free run, bit1 sm event, bits 2-3 = 01 dc.
// - capability bits 4-5 = 00 no sync1 shift, bit 14 dynamic times.
// - read-only minimum cycle time in ns, defaults to 20000.
// - read-only calc-and-copy: minimum sync0-to-sync1 interval, ns, dc only.
// - command 1 starts local cycle measurement, 0 stops; resets zero.
// - measuring updates output and input timing values with largest values seen.
// - starting a new measurement clears previously captured maxima first.
// - read-only delay time: sync1 to outputs driven, ns, dc only.
// - 16-bit count of missed sm events while operational in dc mode.
// - 16-bit count of late-finishing or too-early cycles while operational.
// - 16-bit count of sync0-to-sync1 intervals shorter than required, dc mode.
// - error flag set when last dc cycle drove outputs too late, else cleared.
`include "sync_out_consts.vh"
module output_sync_parameters (
   input wire mclk,
   input wire rst_b,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire sync0_pin,
   input wire sync1_pin,
   input wire sm_event,
   input wire operational,
   input wire out_busy,
   input wire copy_done,
   input wire input_sample,
   input wire input_ready,
   output reg output_strobe,
   output reg measuring,
   output reg [31:0] input_shift_ns,
   output reg [31:0] input_calc_copy_ns,
   output reg [31:0] input_delay_ns
);

   // saturating step for the diagnostic counters
   function [15:0] sat_inc;
      input [15:0] v;
      begin
         sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
      end
   endfunction
   function [31:0] max32;
      input [31:0] a;
      input [31:0] b;
      begin
         max32 = (a > b) ? a : b;
      end
   endfunction

   // byte-lane merge of a write into a stored word
   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[i*8 +: 8] = data[i*8 +: 8];
            end
         end
      end
   endfunction

   reg [15:0] mode;
   reg [31:0] cycle_ns;
   reg [31:0] shift_ns;
   reg [31:0] min_cycle_ns;
   reg [31:0] calc_copy_ns;
   reg [15:0] command;
   reg [31:0] delay_ns;
   reg [15:0] missed_cnt;
   reg [15:0] overrun_cnt;
   reg [15:0] short_cnt;
   reg late_flag;
   reg aw_held;
   reg w_held;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg [2:0] s0_sync;
   reg [2:0] s1_sync;
   reg [31:0] now_ns;
   reg [31:0] ts_sync0;
   reg [31:0] ts_sync1;
   reg [31:0] ts_strobe;
   reg [31:0] ts_sample;
   reg [31:0] timer_ns;
   reg sm_seen;
   reg copy_seen;
   reg sync0_seen;
   reg strobe_seen;
   reg busy_d;
   // write channel: address and data taken in either order
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire wr_go = aw_held & w_held;
   wire [5:0] wr_idx = aw_addr[7:2];
   wire [31:0] mode_new = merge({16'h0000, mode}, w_data, w_strb);
   wire [31:0] cmd_new = merge({16'h0000, command}, w_data, w_strb);
   wire wr_cmd = wr_go & (wr_idx == `IDX_COMMAND);
   // a new run starts only on the 0 to 1 transition, so rewriting 1 keeps maxima
   wire start_meas = wr_cmd & (cmd_new[15:0] == `CMD_START) & ~measuring;
   // sync pins are asynchronous: two flops, the third only feeds the edge detect
   wire sync0_rise = s0_sync[1] & ~s0_sync[2];
   wire sync1_rise = s1_sync[1] & ~s1_sync[2];
   wire dc_mode = (mode == `MODE_SYNC0) | (mode == `MODE_SYNC1);
   wire [32:0] timer_next = {1'b0, timer_ns} + {1'b0, `CLK_PERIOD_NS};
   wire timer_hit = (mode == `MODE_FREE_RUN) & (timer_next >= {1'b0, cycle_ns});
   wire busy_fall = busy_d & ~out_busy;
   wire [31:0] since_sync0 = now_ns - ts_sync0;
   wire [31:0] since_sync1 = now_ns - ts_sync1;
   wire [31:0] since_strobe = now_ns - ts_strobe;
   // output timing source per mode
   reg trig;
   always @* begin
      case (mode)
         `MODE_FREE_RUN: trig = timer_hit;
         `MODE_SM_EVENT: trig = sm_event;
         `MODE_SYNC0: trig = sync0_rise;
         `MODE_SYNC1: trig = sync1_rise;
         default: trig = 1'b0;
      endcase
   end

   wire early = strobe_seen & (since_strobe < min_cycle_ns);
   wire overrun_ev = operational & trig & (out_busy | early);
   wire missed_ev = operational & dc_mode & trig & ~sm_seen & ~sm_event;
   wire short_ev = dc_mode & sync1_rise & sync0_seen & (since_sync0 < calc_copy_ns);
   // bus handshake state and write capture
   always @(posedge mclk) begin
      if (!rst_b) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (read_ok(wr_idx)) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // which indexes are mapped; writes to read-only ones are ignored
   function read_ok;
      input [5:0] idx;
      begin
         case (idx)
            `IDX_ENTRY_COUNT, `IDX_MODE, `IDX_CYCLE, `IDX_SHIFT, `IDX_CAPS,
            `IDX_MIN_CYCLE, `IDX_CALC_COPY, `IDX_COMMAND, `IDX_DELAY,
            `IDX_MISSED, `IDX_OVERRUN, `IDX_SHORT, `IDX_LATE_FLAG: read_ok = 1'b1;
            default: read_ok = 1'b0;
         endcase
      end
   endfunction
   // read mux, narrower registers sit in the low bits
   reg [31:0] rd_val;
   always @* begin
      case (s_axi_araddr[7:2])
         `IDX_ENTRY_COUNT: rd_val = {24'h000000, `ENTRY_COUNT_VAL};
         `IDX_MODE: rd_val = {16'h0000, mode};
         `IDX_CYCLE: rd_val = cycle_ns;
         `IDX_SHIFT: rd_val = shift_ns;
         `IDX_CAPS: rd_val = {16'h0000, `CAPS_VAL};
         `IDX_MIN_CYCLE: rd_val = min_cycle_ns;
         `IDX_CALC_COPY: rd_val = calc_copy_ns;
         `IDX_COMMAND: rd_val = {16'h0000, command};
         `IDX_DELAY: rd_val = delay_ns;
         `IDX_MISSED: rd_val = {16'h0000, missed_cnt};
         `IDX_OVERRUN: rd_val = {16'h0000, overrun_cnt};
         `IDX_SHORT: rd_val = {16'h0000, short_cnt};
         `IDX_LATE_FLAG: rd_val = {31'h00000000, late_flag};
         default: rd_val = 32'h00000000;
      endcase
   end

   // read channel answers one cycle after the address is taken
   always @(posedge mclk) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= read_ok(s_axi_araddr[7:2]) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // writable configuration; undefined mode codes are dropped so timing stays sane
   always @(posedge mclk) begin
      if (!rst_b) begin
         mode <= `MODE_RESET;
         cycle_ns <= `CYCLE_RESET;
         command <= `COMMAND_RESET;
         measuring <= 1'b0;
      end else if (wr_go) begin
         if (wr_idx == `IDX_MODE && mode_new[15:0] <= `MODE_SYNC1) begin
            mode <= mode_new[15:0];
         end
         if (wr_idx == `IDX_CYCLE) begin
            cycle_ns <= merge(cycle_ns, w_data, w_strb);
         end
         if (wr_cmd) begin
            command <= cmd_new[15:0];
            measuring <= (cmd_new[15:0] == `CMD_START);
         end
      end
   end

   // time base, pin synchronisers, local timer and the output strobe
   always @(posedge mclk) begin
      if (!rst_b) begin
         s0_sync <= 3'h0;
         s1_sync <= 3'h0;
         now_ns <= 32'h00000000;
         timer_ns <= 32'h00000000;
         output_strobe <= 1'b0;
         busy_d <= 1'b0;
         ts_sync0 <= 32'h00000000;
         ts_sync1 <= 32'h00000000;
         ts_strobe <= 32'h00000000;
         ts_sample <= 32'h00000000;
         strobe_seen <= 1'b0;
         sync0_seen <= 1'b0;
      end else begin
         s0_sync <= {s0_sync[1:0], sync0_pin};
         s1_sync <= {s1_sync[1:0], sync1_pin};
         now_ns <= now_ns + `CLK_PERIOD_NS;
         busy_d <= out_busy;
         output_strobe <= trig;
         // timer only runs in free run so a mode change restarts a full period
         if (mode != `MODE_FREE_RUN || timer_hit) begin
            timer_ns <= 32'h00000000;
         end else begin
            timer_ns <= timer_next[31:0];
         end
         if (sync0_rise) begin
            ts_sync0 <= now_ns;
            sync0_seen <= 1'b1;
         end
         if (sync1_rise) begin
            ts_sync1 <= now_ns;
         end
         if (trig) begin
            ts_strobe <= now_ns;
            strobe_seen <= 1'b1;
         end
         if (input_sample) begin
            ts_sample <= now_ns;
         end
      end
   end

   // measured maxima; a start clears them before any new sample lands
   always @(posedge mclk) begin
      if (!rst_b) begin
         shift_ns <= 32'h00000000;
         min_cycle_ns <= `MIN_CYCLE_RESET;
         calc_copy_ns <= 32'h00000000;
         delay_ns <= 32'h00000000;
         input_shift_ns <= 32'h00000000;
         input_calc_copy_ns <= 32'h00000000;
         input_delay_ns <= 32'h00000000;
      end else if (start_meas) begin
         shift_ns <= 32'h00000000;
         min_cycle_ns <= 32'h00000000;
         calc_copy_ns <= 32'h00000000;
         delay_ns <= 32'h00000000;
         input_shift_ns <= 32'h00000000;
         input_calc_copy_ns <= 32'h00000000;
         input_delay_ns <= 32'h00000000;
      end else if (measuring) begin
         if (output_strobe & dc_mode) begin
            shift_ns <= max32(shift_ns, since_sync0 - `CLK_PERIOD_NS);
            delay_ns <= max32(delay_ns, since_sync1 - `CLK_PERIOD_NS);
         end
         if (copy_done & dc_mode) begin
            calc_copy_ns <= max32(calc_copy_ns, since_sync0);
         end
         if (busy_fall) begin
            min_cycle_ns <= max32(min_cycle_ns, since_strobe);
         end
         if (input_sample & dc_mode) begin
            input_shift_ns <= max32(input_shift_ns, since_sync0);
            input_delay_ns <= max32(input_delay_ns, since_sync1);
         end
         if (input_ready) begin
            input_calc_copy_ns <= max32(input_calc_copy_ns, now_ns - ts_sample);
         end
      end
   end

   // diagnostics; an event in the clearing cycle still counts as seen
   always @(posedge mclk) begin
      if (!rst_b) begin
         missed_cnt <= 16'h0000;
         overrun_cnt <= 16'h0000;
         short_cnt <= 16'h0000;
         late_flag <= 1'b0;
         sm_seen <= 1'b0;
         copy_seen <= 1'b0;
      end else begin
         sm_seen <= sm_event | (sm_seen & ~trig);
         copy_seen <= copy_done | (copy_seen & ~trig);
         if (missed_ev) begin
            missed_cnt <= sat_inc(missed_cnt);
         end
         if (overrun_ev) begin
            overrun_cnt <= sat_inc(overrun_cnt);
         end
         if (short_ev) begin
            short_cnt <= sat_inc(short_cnt);
         end
         if (!dc_mode) begin
            late_flag <= 1'b0;
         end else if (trig) begin
            late_flag <= ~(copy_seen | copy_done);
         end
      end
   end

endmodule

//--- verilog/sync_out_consts.vh
`ifndef SYNC_OUT_CONSTS_VH
`define SYNC_OUT_CONSTS_VH

// register indexes, byte address is four times the index
`define IDX_ENTRY_COUNT 6'h00
`define IDX_MODE 6'h01
`define IDX_CYCLE 6'h02
`define IDX_SHIFT 6'h03
`define IDX_CAPS 6'h04
`define IDX_MIN_CYCLE 6'h05
`define IDX_CALC_COPY 6'h06
`define IDX_COMMAND 6'h08
`define IDX_DELAY 6'h09
`define IDX_MISSED 6'h0B
`define IDX_OVERRUN 6'h0C
`define IDX_SHORT 6'h0D
`define IDX_LATE_FLAG 6'h20

// reset and fixed values
`define ENTRY_COUNT_VAL 8'h20
`define MODE_RESET 16'h0000
`define CYCLE_RESET 32'h0003D090
`define CAPS_VAL 16'hC007
`define MIN_CYCLE_RESET 32'h00004E20
`define COMMAND_RESET 16'h0000

// synchronization modes
`define MODE_FREE_RUN 16'h0000
`define MODE_SM_EVENT 16'h0001
`define MODE_SYNC0 16'h0002
`define MODE_SYNC1 16'h0003

// command values
`define CMD_START 16'h0001

// clock period in ns at 100 MHz
`define CLK_PERIOD_NS 32'h0000000A

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- testbench/output_sync_parameters_props.sv
module output_sync_parameters_props (
   input wire mclk,
   input wire rst_b,
   input wire s_axi_awready,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire output_strobe,
   input wire measuring,
   input wire [31:0] input_shift_ns,
   input wire [31:0] input_calc_copy_ns
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // bus answers stand until taken; refusals while one is pending
   chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   chk_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   chk_reset_idle: assert property ($rose(rst_b) |-> !s_axi_bvalid && !s_axi_rvalid &&
      !measuring && !output_strobe) else $error("outputs not idle after reset");
   // maxima only grow while measuring, hold once stopped, start from zero
   chk_max_grows: assert property (measuring && $past(measuring) |->
      input_shift_ns >= $past(input_shift_ns) && input_calc_copy_ns >= $past(input_calc_copy_ns))
      else $error("measured maximum shrank");
   chk_stop_holds: assert property (!measuring && !$past(measuring) && !$past(measuring, 2)
      |-> $stable(input_calc_copy_ns)) else $error("value moved while stopped");
   chk_start_clear: assert property ($rose(measuring) |->
      input_calc_copy_ns == 32'h0 && input_shift_ns == 32'h0) else $error("maxima not cleared");
endmodule

bind output_sync_parameters output_sync_parameters_props chk (.mclk(mclk), .rst_b(rst_b),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .output_strobe(output_strobe), .measuring(measuring),
   .input_shift_ns(input_shift_ns), .input_calc_copy_ns(input_calc_copy_ns));

//--- testbench/fieldbus_master_model.sv
module fieldbus_master_model (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic go,
   input wire logic with_sm,
   input wire logic with_copy,
   output logic sync0_pin,
   output logic sync1_pin,
   output logic sm_event,
   output logic copy_done,
   output logic input_sample,
   output logic input_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic run;
   logic [4:0] t;
   // one master cycle per go pulse, stepped by t
   always @(posedge mclk) begin
      if (!rst_b || go) begin
         run <= go;
         t <= 5'h0;
      end else if (run) begin
         t <= t + 5'h1;
         run <= (t != 5'h16);
      end
   end
   // sync pulses last two cycles so the pin synchroniser cannot miss them
   assign sync0_pin = run && (t < 5'h2);
   assign sync1_pin = run && (t == 5'hC || t == 5'hD);
   assign sm_event = run && with_sm && (t == 5'h1);
   assign input_sample = run && (t == 5'h5);
   assign input_ready = run && (t == 5'h9);
   assign copy_done = run && with_copy && (t == 5'h10);
endmodule

//--- testbench/output_sync_parameters_tb_top.sv
`include "sync_out_consts.vh"
module output_sync_parameters_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, rst_b = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, operational = 1, out_busy = 0;
   logic go = 0, with_sm = 0, with_copy = 0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, v, x, m0, o0;
   logic [3:0] s_axi_wstrb = 4'hF;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, measuring;
   wire sync0_pin, sync1_pin, sm_event, copy_done, input_sample, input_ready, output_strobe;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata, input_shift_ns, input_calc_copy_ns, input_delay_ns;
   int err_total = 0, checks = 0, n_strobe = 0, base;
   logic [7:0] ra [13] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24,
      8'h2C, 8'h30, 8'h34, 8'h80};
   logic [31:0] rv [13] = '{32'h20, 32'h0, 32'h0003D090, 32'h0, 32'hC007, 32'h4E20, 32'h0,
      32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

   output_sync_parameters uut (.mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .sync0_pin(sync0_pin), .sync1_pin(sync1_pin),
      .sm_event(sm_event), .operational(operational), .out_busy(out_busy),
      .copy_done(copy_done), .input_sample(input_sample), .input_ready(input_ready),
      .output_strobe(output_strobe), .measuring(measuring), .input_shift_ns(input_shift_ns),
      .input_calc_copy_ns(input_calc_copy_ns), .input_delay_ns(input_delay_ns));
   fieldbus_master_model far (.mclk(mclk), .rst_b(rst_b), .go(go), .with_sm(with_sm),
      .with_copy(with_copy), .sync0_pin(sync0_pin), .sync1_pin(sync1_pin), .sm_event(sm_event),
      .copy_done(copy_done), .input_sample(input_sample), .input_ready(input_ready));

   // free-running clock and a tally of output strobes
   always #5 mclk = ~mclk;
   always @(posedge mclk) if (output_strobe === 1'b1) n_strobe++;

   task automatic finish_test;
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // mode writes beyond the last defined code leave the mode as it was
   function automatic logic [31:0] mode_after(input logic [31:0] cur, input logic [31:0] w);
      return (w <= 32'h3) ? w : cur;
   endfunction

   // bounded wait that ends the run when the answer never comes
   task automatic give_up(input int n);
      if (n >= 50) begin
         err_total++;
         finish_test();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic ta, tw, tb;
      logic [1:0] r;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      do begin
         #1;
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         n++;
         @(posedge mclk);
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
         s_axi_bready <= !tb;
      end while (!tb && n < 50);
      give_up(n);
      chk({30'h0, r}, {30'h0, er});
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      int n;
      logic ta, tr;
      logic [1:0] r;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do begin
         #1;
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid && s_axi_rready;
         r = s_axi_rresp;
         d = s_axi_rdata;
         n++;
         @(posedge mclk);
         if (ta) s_axi_arvalid <= 0;
         s_axi_rready <= !tr;
      end while (!tr && n < 50);
      give_up(n);
      chk({30'h0, r}, {30'h0, er});
   endtask

   // one master cycle from the far side, counting strobes it causes
   task automatic burst(input logic s, input logic c, input int exp);
      base = n_strobe;
      with_sm <= s;
      with_copy <= c;
      go <= 1;
      @(posedge mclk);
      go <= 0;
      repeat (26) @(posedge mclk);
      chk(n_strobe - base, exp);
   endtask

   // main sequence
   initial begin
      void'($urandom(32'h088F));
      repeat (3) @(posedge mclk);
      rst_b <= 1;
      @(posedge mclk);
      for (int i = 0; i < 13; i++) begin
         rd(ra[i], `RESP_OKAY, v);
         chk(v, rv[i]);
      end
      wr(8'h10, 32'h0, `RESP_OKAY);
      rd(8'h10, `RESP_OKAY, v);
      chk(v, 32'hC007);
      wr(8'h1C, 32'h1, `RESP_SLVERR);
      rd(8'h1C, `RESP_SLVERR, v);
      chk(v, 32'h0);
      for (int m = 0; m < 4; m++) begin
         wr(8'h04, m, `RESP_OKAY);
         rd(8'h04, `RESP_OKAY, v);
         chk(v, m);
         burst(1, 1, (m == 0) ? 0 : 1);
      end
      x = 32'h4 + $urandom_range(200);
      wr(8'h04, x, `RESP_OKAY);
      rd(8'h04, `RESP_OKAY, v);
      chk(v, mode_after(32'h3, x));
      x = $urandom;
      wr(8'h08, x, `RESP_OKAY);
      rd(8'h08, `RESP_OKAY, v);
      chk(v, x);
      // missed events, overruns and the late flag in sync0 mode
      wr(8'h04, 32'h2, `RESP_OKAY);
      rd(8'h2C, `RESP_OKAY, m0);
      rd(8'h30, `RESP_OKAY, o0);
      burst(1, 1, 1);
      repeat (3) burst(0, 0, 1);
      rd(8'h2C, `RESP_OKAY, v);
      chk(v, m0 + 3);
      rd(8'h30, `RESP_OKAY, v);
      chk(v, o0 + 4);
      rd(8'h80, `RESP_OKAY, v);
      chk(v, 32'h1);
      repeat (2) burst(1, 1, 1);
      rd(8'h80, `RESP_OKAY, v);
      chk(v, 32'h0);
      // measurement start, capture, stop and restart
      wr(8'h20, 32'h1, `RESP_OKAY);
      chk({31'h0, measuring}, 32'h1);
      burst(1, 1, 1);
      chk(input_calc_copy_ns, 32'h28);
      chk(input_shift_ns, 32'h1E);
      // the captured calc-copy maximum makes the next sync0-to-sync1 gap too short
      rd(8'h34, `RESP_OKAY, m0);
      burst(1, 1, 1);
      rd(8'h34, `RESP_OKAY, v);
      chk(v, m0 + 1);
      wr(8'h20, 32'h0, `RESP_OKAY);
      chk({31'h0, measuring}, 32'h0);
      rd(8'h18, `RESP_OKAY, v);
      chk(v, 32'h8C);
      wr(8'h20, 32'h1, `RESP_OKAY);
      chk(input_calc_copy_ns, 32'h0);
      chk(input_delay_ns, 32'h0);
      // outside operational no missed event or overrun counts; busy at the trigger is an overrun
      rd(8'h2C, `RESP_OKAY, m0);
      rd(8'h30, `RESP_OKAY, o0);
      operational <= 0;
      burst(0, 0, 1);
      operational <= 1;
      out_busy <= 1;
      burst(1, 1, 1);
      out_busy <= 0;
      rd(8'h2C, `RESP_OKAY, v);
      chk(v, m0);
      rd(8'h30, `RESP_OKAY, v);
      chk(v, o0 + 1);
      rd(8'h14, `RESP_OKAY, v);
      chk(v, 32'hF0);
      // free run: strobe period follows the cycle time
      wr(8'h04, 32'h0, `RESP_OKAY);
      for (int c = 3; c <= 5; c += 2) begin
         wr(8'h08, c * 10, `RESP_OKAY);
         repeat (12) @(negedge mclk);
         base = n_strobe;
         repeat (30) @(negedge mclk);
         chk(n_strobe - base, 30 / c);
         @(posedge mclk);
      end
      finish_test();
   end
endmodule
